// ==== shared/laser_cfg_pkg.sv ====
// Shared constants and types for the laser reset, enable and configuration block
package laser_cfg_pkg;
  localparam int unsigned DATA_W          = 16;
  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_RESET_AND_OUTPUT_ENABLE      = 8'h32;
  localparam logic [7:0]  IDX_CONFIG      = 8'h33;
  localparam logic [7:0]  IDX_IRQ_STATUS  = 8'h40;
  localparam logic [7:0]  IDX_IRQ_MASK    = 8'h41;
  localparam logic [7:0]  IDX_CONTROL     = 8'h42;
  localparam logic [7:0]  IDX_STATUS      = 8'h43;
  // Field positions
  localparam int unsigned RE_HARD_BIT     = 0;
  localparam int unsigned RE_SOFT_BIT     = 1;
  localparam int unsigned RE_SOFTWARE_OUTPUT_ENABLE_BIT     = 3;
  localparam int unsigned CFG_ADT_BIT     = 1;
  localparam int unsigned CFG_SDF_BIT     = 2;
  localparam int unsigned CTRL_SAVE_BIT   = 0;
  // Implemented bits and values after reset
  localparam logic [15:0] RESET_AND_OUTPUT_ENABLE_MASK     = 16'h000B;
  localparam logic [15:0] CONFIG_MASK     = 16'h0006;
  localparam logic [15:0] FATAL_BITS_MASK = 16'h0700;
  localparam logic [15:0] RESET_AND_OUTPUT_ENABLE_RESET    = 16'h0000;
  localparam logic [15:0] CONFIG_FACTORY  = 16'h0002;
  // Interrupt status bits
  localparam int unsigned IRQ_W           = 4;
  localparam int unsigned IRQ_RESET_DONE  = 0;
  localparam int unsigned IRQ_TUNE_DONE   = 1;
  localparam int unsigned IRQ_FATAL_SHUT  = 2;
  localparam int unsigned IRQ_DISABLED    = 3;
  localparam logic [IRQ_W-1:0] IRQ_RESET  = 4'h0;
  // Length of the reset pulse given to the interface and loops
  localparam int unsigned RESET_PULSE_CYCLES = 4;
  localparam logic [2:0]  HSIZE_WORD      = 3'h2;
  typedef enum logic [1:0]
  {
    SEQ_IDLE  = 2'b00,
    SEQ_ACK   = 2'b01,
    SEQ_PULSE = 2'b11
  } seq_state_t;
endpackage

// ==== design/reset_sequencer.sv ====
// Orders reset requests: acknowledge first, then a timed reset pulse
`timescale 1ns/1ps
`default_nettype none
module reset_sequencer
  import laser_cfg_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = RESET_PULSE_CYCLES
)
(
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic req_hard,
  input  wire logic req_soft,
  input  wire logic deselected,
  output logic      taken,
  output logic      done_pulse,
  output logic      comm_if_reset,
  output logic      control_loop_reset
);
  initial assert (PULSE_CYCLES >= 1 && PULSE_CYCLES < 256) else $error("PULSE_CYCLES out of range");

  seq_state_t state_reg;
  logic [7:0] count_reg;
  logic       hard_reg;

  assign taken = (state_reg == SEQ_IDLE) && (req_hard || req_soft);

  // Request accepted, one idle cycle for the response, then the pulse
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= SEQ_IDLE;
      count_reg <= 8'h00;
      hard_reg  <= 1'b0;
    end
    else
    begin
      case (state_reg)
        SEQ_IDLE:
        begin
          if (taken)
          begin
            state_reg <= SEQ_ACK;
            hard_reg  <= req_hard;
          end
        end
        SEQ_ACK:
        begin
          state_reg <= SEQ_PULSE;
          count_reg <= 8'(PULSE_CYCLES - 1);
        end
        SEQ_PULSE:
        begin
          if (count_reg == 8'h00)
            state_reg <= SEQ_IDLE;
          else
            count_reg <= count_reg - 8'h01;
        end
        default: state_reg <= SEQ_IDLE;
      endcase
    end
  end

  // Soft and hard both reset the interface; only hard touches the loops
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      comm_if_reset      <= 1'b0;
      control_loop_reset <= 1'b0;
      done_pulse         <= 1'b0;
    end
    else
    begin
      comm_if_reset      <= (state_reg == SEQ_ACK) || (state_reg == SEQ_PULSE && count_reg != 8'h00)
                            || deselected;
      control_loop_reset <= hard_reg && ((state_reg == SEQ_ACK) ||
                            (state_reg == SEQ_PULSE && count_reg != 8'h00));
      done_pulse         <= (state_reg == SEQ_PULSE) && (count_reg == 8'h00);
    end
  end

  a_hard_pulse_len: assert property (@(posedge clk) disable iff (!reset_n)
    taken && req_hard |=> !control_loop_reset ##1 control_loop_reset [*4] ##1 !control_loop_reset)
    else $error("hard reset pulse not four cycles after ack");
  a_soft_keeps_loops: assert property (@(posedge clk) disable iff (!reset_n)
    taken && !req_hard |=> ##1 !control_loop_reset [*5])
    else $error("soft reset touched control loops");
endmodule
`default_nettype wire

// ==== design/output_disable_logic.sv ====
// Combines enable, disable pin and masked fatal status; drives the alarm
`timescale 1ns/1ps
`default_nettype none
module output_disable_logic
  import laser_cfg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        software_output_enable,
  input  wire logic        hw_disable_n,
  input  wire logic [15:0] fatal_status,
  input  wire logic [15:0] fatal_trigger,
  input  wire logic        shutdown_on_fatal,
  input  wire logic        alarm_during_tuning,
  input  wire logic        tuning,
  output logic             output_disable,
  output logic             alarm,
  output logic             fatal
);
  logic fatal_now;
  logic disable_now;

  // Fatal only from bits ten to eight, gated by the trigger mask
  assign fatal_now   = |(fatal_status & fatal_trigger & FATAL_BITS_MASK);
  assign disable_now = (fatal_now && shutdown_on_fatal) || !software_output_enable || !hw_disable_n;

  // Registered so the pin never glitches on a mask or status change
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      output_disable <= 1'b1;
      alarm          <= 1'b0;
      fatal          <= 1'b0;
    end
    else
    begin
      output_disable <= disable_now;
      alarm          <= alarm_during_tuning && (tuning || disable_now);
      fatal          <= fatal_now;
    end
  end

  a_disable_term: assert property (@(posedge clk) disable iff (!reset_n)
    (!software_output_enable || !hw_disable_n) |=> output_disable)
    else $error("output not disabled with enable off");
  a_fatal_shut: assert property (@(posedge clk) disable iff (!reset_n)
    software_output_enable && hw_disable_n && fatal_now |=> output_disable == $past(shutdown_on_fatal))
    else $error("fatal shutdown does not follow sdf");
  a_alarm_lock: assert property (@(posedge clk) disable iff (!reset_n)
    alarm_during_tuning && !tuning && !disable_now |=> !alarm)
    else $error("alarm held after successful tune");
endmodule
`default_nettype wire

// ==== design/laser_output_reset_enable_config.sv ====
// AHB-Lite register bank for laser reset, output enable and behaviour config
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Enable bit one enables the optical output, zero disables it.
// - Enabling while a tune is needed reports the operation as pending.
// - Hard and soft reset requested together performs only the hard reset.
// - Soft reset reinitialises the interface, leaving traffic and loops untouched.
// - Hard reset also reinitialises control loops; optical effect undefined.
// - Reset request is acknowledged before the reset begins.
// - Both reset bits clear themselves and reset to zero.
// - Output disabled on masked fatal with shutdown set, enable low, or pin low.
// - Enable reads zero if software cleared it or the pin went low.
// - Alarm-during-tuning raises the alarm while tuning or disabled.
// - Shutdown-on-fatal set disables output on fatal; cleared it does not.
// - Fatal condition is any of fatal status bits ten to eight that is also set in the trigger mask.
// - Config defaults to factory value, replaceable by a saved default.
module laser_output_reset_enable_config
#(
  parameter int unsigned ADDR_W = 10
)
(
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic              hready,
  input  wire logic [31:0]       hwdata,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  input  wire logic              hardware_disable_n,
  input  wire logic              module_select_n,
  input  wire logic [15:0]       fatal_status_reg,
  input  wire logic [15:0]       fatal_trigger,
  input  wire logic              tuning_active,
  input  wire logic              tune_required,
  input  wire logic              tune_done_ok,
  input  wire logic [15:0]       nv_default_value,
  input  wire logic              nv_default_valid,
  output logic                   optical_output_disable,
  output logic                   module_alarm_line,
  output logic                   comm_if_reset,
  output logic                   control_loop_reset,
  output logic                   tune_request,
  output logic                   nv_store_req,
  output logic      [15:0]       nv_store_data,
  output logic                   irq
);
  import laser_cfg_pkg::*;

  initial assert (ADDR_W >= 10 && ADDR_W <= 32) else $error("ADDR_W must hold index 0x43");

  // Index of a word address; unaligned addresses never match a register
  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
    reg_index = (a[1:0] == 2'b00) ? a[9:2] : 8'hFF;
  endfunction

  logic [1:0]       hwdis_sync_reg;
  logic [1:0]       msel_sync_reg;
  logic             wr_pend_reg;
  logic             rd_pend_reg;
  logic [7:0]       wr_idx_reg;
  logic [7:0]       rd_idx_reg;
  logic             software_output_enable_reg;
  logic [1:0]       req_bits_reg;
  logic [15:0]      cfg_reg;
  logic             nv_loaded_reg;
  logic             pending_reg;
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic             disable_prev_reg;
  logic             fatal_shut_prev_reg;
  logic             addr_ok;
  logic             wr_reset_and_output_enable;
  logic             wr_hard;
  logic             wr_soft;
  logic             seq_taken;
  logic             seq_done;
  logic             fatal_now;
  logic             tune_finish;
  logic [IRQ_W-1:0] irq_event;
  logic [31:0]      rd_mux;

  // Pins come from outside the clock domain
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hwdis_sync_reg <= 2'b11;
      msel_sync_reg  <= 2'b11;
    end
    else
    begin
      hwdis_sync_reg <= {hwdis_sync_reg[0], hardware_disable_n};
      msel_sync_reg  <= {msel_sync_reg[0], module_select_n};
    end
  end

  // Only whole-word transfers are decoded
  assign addr_ok = hsel && hready && htrans[1] && (hsize == HSIZE_WORD);

  // Bus phase tracking: writes are zero-wait, reads take one wait state
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      wr_idx_reg  <= 8'h00;
      rd_idx_reg  <= 8'h00;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end
    else
    begin
      wr_pend_reg <= addr_ok && hwrite;
      rd_pend_reg <= addr_ok && !hwrite;
      hreadyout   <= !(addr_ok && !hwrite);
      hresp       <= 1'b0;
      if (addr_ok)
      begin
        wr_idx_reg <= reg_index(haddr);
        rd_idx_reg <= reg_index(haddr);
      end
    end
  end

  // The wait state lets a preceding write land before the read is sampled
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (rd_idx_reg)
      IDX_RESET_AND_OUTPUT_ENABLE:     rd_mux[15:0] = {12'h000, software_output_enable_reg, 1'b0, req_bits_reg[1], req_bits_reg[0]};
      IDX_CONFIG:     rd_mux[15:0] = cfg_reg & CONFIG_MASK;
      IDX_IRQ_STATUS: rd_mux[IRQ_W-1:0] = irq_status_reg;
      IDX_IRQ_MASK:   rd_mux[IRQ_W-1:0] = irq_mask_reg;
      IDX_STATUS:     rd_mux[3:0] = {hwdis_sync_reg[1], fatal_now, optical_output_disable, pending_reg};
      default:        rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      hrdata <= 32'h0000_0000;
    else if (rd_pend_reg)
      hrdata <= rd_mux;
  end

  // Hard wins when both reset bits are written together
  assign wr_reset_and_output_enable = wr_pend_reg && (wr_idx_reg == IDX_RESET_AND_OUTPUT_ENABLE);
  assign wr_hard   = wr_reset_and_output_enable && hwdata[RE_HARD_BIT];
  assign wr_soft   = wr_reset_and_output_enable && hwdata[RE_SOFT_BIT] && !hwdata[RE_HARD_BIT];

  // Request bits self-clear when the sequencer takes them; a new write wins
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      req_bits_reg <= RESET_AND_OUTPUT_ENABLE_RESET[1:0];
    else if (wr_hard)
      req_bits_reg <= 2'b01;
    else if (wr_soft)
      req_bits_reg <= {1'b1, req_bits_reg[0]};
    else if (seq_taken)
      req_bits_reg <= 2'b00;
  end

  // Enable bit; the disable pin forces it low so software can see why
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      software_output_enable_reg <= RESET_AND_OUTPUT_ENABLE_RESET[RE_SOFTWARE_OUTPUT_ENABLE_BIT];
    else if (!hwdis_sync_reg[1])
      software_output_enable_reg <= 1'b0;
    else if (wr_reset_and_output_enable)
      software_output_enable_reg <= hwdata[RE_SOFTWARE_OUTPUT_ENABLE_BIT];
  end

  // Turning the output on may need a tune: flag it pending until done
  assign tune_finish = pending_reg && tune_done_ok;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pending_reg  <= 1'b0;
      tune_request <= 1'b0;
    end
    else
    begin
      tune_request <= wr_reset_and_output_enable && hwdata[RE_SOFTWARE_OUTPUT_ENABLE_BIT] && !software_output_enable_reg && tune_required && hwdis_sync_reg[1];
      if (wr_reset_and_output_enable && hwdata[RE_SOFTWARE_OUTPUT_ENABLE_BIT] && !software_output_enable_reg && tune_required && hwdis_sync_reg[1])
        pending_reg <= 1'b1;
      else if (tune_done_ok)
        pending_reg <= 1'b0;
    end
  end

  // Factory default at reset, replaced by a stored default if valid in the first cycle after reset
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_reg       <= CONFIG_FACTORY;
      nv_loaded_reg <= 1'b0;
    end
    else if (wr_pend_reg && wr_idx_reg == IDX_CONFIG)
    begin
      cfg_reg       <= hwdata[15:0] & CONFIG_MASK;
      nv_loaded_reg <= 1'b1;
    end
    else if (!nv_loaded_reg)
    begin
      nv_loaded_reg <= 1'b1;
      if (nv_default_valid)
        cfg_reg <= nv_default_value & CONFIG_MASK;
    end
  end

  // Saving hands the current config to the storage controller
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      nv_store_req  <= 1'b0;
      nv_store_data <= CONFIG_FACTORY;
    end
    else
    begin
      nv_store_req <= wr_pend_reg && (wr_idx_reg == IDX_CONTROL) && hwdata[CTRL_SAVE_BIT];
      if (wr_pend_reg && (wr_idx_reg == IDX_CONTROL) && hwdata[CTRL_SAVE_BIT])
        nv_store_data <= cfg_reg;
    end
  end

  reset_sequencer #(
    .PULSE_CYCLES (RESET_PULSE_CYCLES)
  ) u_reset_sequencer (
    .clk                (clk),
    .reset_n            (reset_n),
    .req_hard           (req_bits_reg[0]),
    .req_soft           (req_bits_reg[1]),
    .deselected         (msel_sync_reg[1]),
    .taken              (seq_taken),
    .done_pulse         (seq_done),
    .comm_if_reset      (comm_if_reset),
    .control_loop_reset (control_loop_reset)
  );

  output_disable_logic u_output_disable_logic (
    .clk            (clk),
    .reset_n        (reset_n),
    .software_output_enable           (software_output_enable_reg),
    .hw_disable_n   (hwdis_sync_reg[1]),
    .fatal_status   (fatal_status_reg),
    .fatal_trigger  (fatal_trigger),
    .shutdown_on_fatal            (cfg_reg[CFG_SDF_BIT]),
    .alarm_during_tuning            (cfg_reg[CFG_ADT_BIT]),
    .tuning         (tuning_active),
    .output_disable (optical_output_disable),
    .alarm          (module_alarm_line),
    .fatal          (fatal_now)
  );

  // Edge history for the shutdown and disable events
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      disable_prev_reg    <= 1'b1;
      fatal_shut_prev_reg <= 1'b0;
    end
    else
    begin
      disable_prev_reg    <= optical_output_disable;
      fatal_shut_prev_reg <= fatal_now && cfg_reg[CFG_SDF_BIT];
    end
  end

  assign irq_event[IRQ_RESET_DONE] = seq_done;
  assign irq_event[IRQ_TUNE_DONE]  = tune_finish;
  assign irq_event[IRQ_FATAL_SHUT] = fatal_now && cfg_reg[CFG_SDF_BIT] && !fatal_shut_prev_reg;
  assign irq_event[IRQ_DISABLED]   = optical_output_disable && !disable_prev_reg;

  // Sticky status, write one to clear; an event in the clear cycle survives
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      irq_status_reg <= IRQ_RESET;
      irq_mask_reg   <= IRQ_RESET;
      irq            <= 1'b0;
    end
    else
    begin
      if (wr_pend_reg && wr_idx_reg == IDX_IRQ_STATUS)
        irq_status_reg <= (irq_status_reg & ~hwdata[IRQ_W-1:0]) | irq_event;
      else
        irq_status_reg <= irq_status_reg | irq_event;
      if (wr_pend_reg && wr_idx_reg == IDX_IRQ_MASK)
        irq_mask_reg <= hwdata[IRQ_W-1:0];
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end

  a_hard_priority: assert property (@(posedge clk) disable iff (!reset_n)
    wr_reset_and_output_enable && hwdata[RE_HARD_BIT] && hwdata[RE_SOFT_BIT] |=> req_bits_reg == 2'b01)
    else $error("soft reset kept alongside hard reset");
  a_software_output_enable_write: assert property (@(posedge clk) disable iff (!reset_n)
    wr_reset_and_output_enable && hwdis_sync_reg[1] |=> software_output_enable_reg == $past(hwdata[RE_SOFTWARE_OUTPUT_ENABLE_BIT]))
    else $error("enable bit did not take written value");
  a_pin_clears_software_output_enable: assert property (@(posedge clk) disable iff (!reset_n)
    !hwdis_sync_reg[1] |=> !software_output_enable_reg ##1 optical_output_disable)
    else $error("disable pin did not clear enable");
  a_reset_self_clear: assert property (@(posedge clk) disable iff (!reset_n)
    wr_hard |=> req_bits_reg[0] ##[1:20] req_bits_reg == 2'b00)
    else $error("reset bit did not clear");
  a_read_wait: assert property (@(posedge clk) disable iff (!reset_n)
    addr_ok && !hwrite |=> !hreadyout ##1 (hreadyout && hrdata[31:16] == 16'h0000))
    else $error("read timing or upper bits wrong");
  a_pending_ends: assert property (@(posedge clk) disable iff (!reset_n)
    pending_reg && tune_done_ok && !wr_reset_and_output_enable |=> !pending_reg)
    else $error("pending not cleared by tune done");
  a_deselect_reset: assert property (@(posedge clk) disable iff (!reset_n)
    msel_sync_reg[1] |=> comm_if_reset)
    else $error("deselect did not reset interface");
  a_irq_sticky: assert property (@(posedge clk) disable iff (!reset_n)
    irq_event[IRQ_RESET_DONE] |=> irq_status_reg[IRQ_RESET_DONE])
    else $error("event lost in status");
endmodule
`default_nettype wire

// ==== testbench/host_bus_model.sv ====
// Host controller model issuing single word AHB-Lite transfers
`timescale 1ns/1ps
`default_nettype none
module host_bus_model
  import laser_cfg_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  output logic      [9:0]  haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  // Idle bus at time zero; only word transfers are ever issued
  initial
  begin
    haddr = 10'h000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
  end
  // Address held until hready, then data held until hready; read data taken there
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    q = hrdata;
    // Stale data would hide a slave that samples late, so invert it
    hwdata <= ~d;
  endtask
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// Self-checking bench for the laser reset, enable and configuration registers
`timescale 1ns/1ps
`default_nettype none
module tb;
  import laser_cfg_pkg::*;
  logic        clk;
  logic        reset_n;
  logic        pin_n;
  logic        sel_n;
  logic        tuning;
  logic        tune_req_in;
  logic        tune_ok;
  logic [15:0] fstat;
  logic [15:0] ftrig;
  logic        nv_ok;
  wire  logic        hresp;
  wire  logic        nvreq;
  wire  logic [9:0]  haddr;
  wire  logic [1:0]  htrans;
  wire  logic        hwrite;
  wire  logic [2:0]  hsize;
  wire  logic [31:0] hwdata;
  wire  logic [31:0] hrdata;
  wire  logic        hready;
  wire  logic        dis;
  wire  logic        alarm;
  wire  logic        cir;
  wire  logic        clr;
  wire  logic        treq;
  wire  logic        irq;
  wire  logic [15:0] nvdata;
  int          num_errors;
  int          cmp_count;
  int          cycles;
  int          n;
  int          i;
  logic        h;
  logic [31:0] seed;
  logic [31:0] rd;
  logic [31:0] v;
  logic [15:0] fs;
  localparam logic [9:0] A_RE = {IDX_RESET_AND_OUTPUT_ENABLE, 2'b00};
  localparam logic [9:0] A_CF = {IDX_CONFIG, 2'b00};
  localparam logic [9:0] A_IS = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [9:0] A_IM = {IDX_IRQ_MASK, 2'b00};
  localparam logic [9:0] A_ST = {IDX_STATUS, 2'b00};
  laser_output_reset_enable_config u_laser_output_reset_enable_config
  (
    .clk(clk), .reset_n(reset_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hready), .hresp(hresp), .hardware_disable_n(pin_n), .module_select_n(sel_n),
    .fatal_status_reg(fstat), .fatal_trigger(ftrig), .tuning_active(tuning),
    .tune_required(tune_req_in), .tune_done_ok(tune_ok), .nv_default_value(16'h0004),
    .nv_default_valid(nv_ok), .optical_output_disable(dis), .module_alarm_line(alarm),
    .comm_if_reset(cir), .control_loop_reset(clr), .tune_request(treq),
    .nv_store_req(nvreq), .nv_store_data(nvdata), .irq(irq)
  );
  host_bus_model u_host_bus_model
  (
    .clk(clk), .hready(hready), .hrdata(hrdata), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata)
  );
  // Expected disable term from enable, pin, masked fatal and shutdown setting
  function automatic logic exp_dis(logic s, logic p, logic [15:0] f, logic [15:0] t, logic sd);
    return ((|(f & t & FATAL_BITS_MASK)) && sd) || !s || !p;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    u_host_bus_model.xfer(1'b1, a, d, rd);
  endtask
  task automatic rdc(input logic [9:0] a, input logic [31:0] e, input logic [31:0] m);
    u_host_bus_model.xfer(1'b0, a, 32'h0, rd);
    chk($sformatf("reg %h", a), e, rd & m);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic end_of_test;
    if (num_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // 250 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // A hang is cut short well beyond the expected run length
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      end_of_test;
    end
  end
  initial
  begin
    {num_errors, cmp_count, cycles} = '0;
    seed = 32'he61ef946;
    reset_n = 1'b0;
    {pin_n, sel_n, tuning, tune_req_in, tune_ok} = 5'b10000;
    {fstat, ftrig} = '0;
    nv_ok = 1'b0;
    cyc(2);
    reset_n <= 1'b1;
    rdc(A_RE, RESET_AND_OUTPUT_ENABLE_RESET, 32'hFFFFFFFF);
    rdc(A_CF, CONFIG_FACTORY, 32'hFFFFFFFF);
    rdc(10'h3FC, 32'h0, 32'hFFFFFFFF);
    chk("dis", 1'b1, dis);
    // Random config words, upper and unused bits must vanish
    for (i = 0; i < 6; i++)
    begin
      v = $random(seed);
      wr(A_CF, v);
      rdc(A_CF, v & CONFIG_MASK, 32'hFFFFFFFF);
    end
    wr({IDX_CONTROL, 2'b00}, 32'h1);
    cyc(1);
    chk("nvreq", 1'b1, nvreq);
    cyc(2);
    chk("nvdata", v & CONFIG_MASK, nvdata);
    wr(A_CF, 32'h2);
    wr(A_RE, 32'h8);
    rdc(A_RE, 32'h8, 32'hFFFFFFFF);
    cyc(2);
    chk("dis", 1'b0, dis);
    chk("alarm", 1'b0, alarm);
    tuning <= 1'b1;
    cyc(3);
    chk("alarm", 1'b1, alarm);
    tuning <= 1'b0;
    // Each fatal bit, plus one just outside the fatal field
    ftrig <= 16'hFFFF;
    wr(A_CF, 32'h6);
    for (i = 0; i < 4; i++)
    begin
      fs = (i < 3) ? (16'h0100 << i) : 16'h0800;
      fstat <= fs | (16'h0001 << ($random(seed) & 32'h7));
      cyc(3);
      chk("dis", exp_dis(1, 1, fstat, ftrig, 1), dis);
    end
    fstat <= 16'h0200;
    wr(A_CF, 32'h2);
    cyc(3);
    chk("dis", 1'b0, dis);
    fstat <= 16'h0000;
    pin_n <= 1'b0;
    cyc(6);
    chk("dis", 1'b1, dis);
    chk("alarm", 1'b1, alarm);
    wr(A_RE, 32'h8);
    rdc(A_RE, 32'h0, 32'h8);
    pin_n <= 1'b1;
    cyc(4);
    wr(A_RE, 32'h8);
    cyc(3);
    chk("dis", 1'b0, dis);
    wr(A_RE, 32'h0);
    tune_req_in <= 1'b1;
    wr(A_RE, 32'h8);
    n = 0;
    while (treq !== 1'b1 && n < 8)
    begin
      cyc(1);
      n++;
    end
    chk("treq", 1'b1, treq);
    rdc(A_ST, 32'h1, 32'h1);
    tune_ok <= 1'b1;
    cyc(1);
    tune_ok <= 1'b0;
    tune_req_in <= 1'b0;
    rdc(A_ST, 32'h0, 32'h1);
    // Both bits, soft only, then soft with the interrupt masked
    for (i = 0; i < 3; i++)
    begin
      wr(A_IM, (i < 2) ? 32'h1 : 32'h0);
      wr(A_RE, (i == 0) ? 32'hB : 32'hA);
      n = 0;
      h = 1'b0;
      repeat (14)
      begin
        cyc(1);
        n += int'(cir);
        h |= clr;
      end
      chk("cir pulse", RESET_PULSE_CYCLES, n);
      chk("clr seen", (i == 0), h);
      chk("dis", 1'b0, dis);
      chk("irq", (i < 2), irq);
      rdc(A_RE, 32'h8, 32'hFFFFFFFF);
      wr(A_IS, 32'hF);
      cyc(2);
      chk("irq", 1'b0, irq);
    end
    sel_n <= 1'b1;
    cyc(6);
    chk("cir", 1'b1, cir);
    sel_n <= 1'b0;
    cyc(6);
    chk("cir", 1'b0, cir);
    // Mid-run reset with a stored default present; it must replace the factory value
    nv_ok <= 1'b1;
    reset_n <= 1'b0;
    cyc(2);
    chk("dis", 1'b1, dis);
    reset_n <= 1'b1;
    rdc(A_CF, 32'h4, 32'hFFFFFFFF);
    rdc(A_RE, RESET_AND_OUTPUT_ENABLE_RESET, 32'hFFFFFFFF);
    chk("hresp", 1'b0, hresp);
    end_of_test;
  end
endmodule
`default_nettype wire
